/* File: hw/ldi_pkg.sv */
// Overview of operation
// - power-up clears every register and leaves the device asleep
// - enable low forces shutdown: registers held reset, serial port disabled
// - enable high with sleep release bit zero means sleep mode
// - power register bit 0: zero sleep, one normal; resets to zero
// - entering or leaving sleep keeps all register contents
// - level register resets to zero; zero means no output, 1..255 linear
// - output bridge swaps polarity of both outputs at about 1.1 kHz
// - device is slave only; master clocks; data line open-drain
// - start is data falling with clock high, stop is data rising
// - one bit per clock pulse, data stable while clock high
// - ninth clock carries acknowledge pulled low by the receiver
// - address byte 0xec writes, 0xed reads
// - first byte after write address is stored as register pointer
// - write data fills pointed register, pointer advances per byte
// - read data starts at pointer, pointer advances per byte
// - after master not-acknowledge the device stops driving data
// - sleep keeps high-voltage drive inactive
`default_nettype none

package ldi_pkg;

   // ===========================================================
   // register map
   localparam logic [7:0] REG_POWER_OFS = 8'h00;
   localparam logic [7:0] REG_LEVEL_OFS = 8'h01;
   localparam logic [7:0] POWER_RESET = 8'h00;
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   localparam int SLEEP_RELEASE_POS = 0;

   // ===========================================================
   // serial protocol
   localparam logic [7:0] DEV_ADDR_WRITE = 8'hec;
   localparam logic [7:0] DEV_ADDR_READ = 8'hed;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;

   // ===========================================================
   // timing
   localparam int CLK_HZ = 200_000_000;
   localparam int BRIDGE_RATE_HZ = 1100;
   localparam int BRIDGE_HALF_CYCLES = CLK_HZ / (2 * BRIDGE_RATE_HZ);

   // ===========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_REG = 3'h2,
      ST_WDATA = 3'h3,
      ST_RDATA = 3'h4,
      ST_SKIP = 3'h5
   } ldi_state_t;

   typedef struct packed {
      logic [7:0] power;
      logic [7:0] level;
   } ldi_regs_t;

   localparam ldi_regs_t REGS_RESET = '{power: POWER_RESET,
                                       level: LEVEL_RESET};

endpackage

`default_nettype wire

/* File: hw/ldi_lens_driver.sv */
`default_nettype none

module ldi_lens_driver
   import ldi_pkg::*;
#(
   parameter int HALF_CYCLES = BRIDGE_HALF_CYCLES
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic SER_CLK,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic EN,
   output logic HV_OUT_POS,
   output logic HV_OUT_NEG,
   output logic [7:0] PEAK_LEVEL_CODE,
   output logic NORMAL_MODE
);

   localparam int CW = $clog2(HALF_CYCLES + 1);

   // ===========================================================
   // register access helpers
   // unmapped pointer values read as zero
   function automatic logic [7:0] read_reg(input ldi_regs_t r,
                                           input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a == REG_POWER_OFS) begin
         d = r.power;
      end else if (a == REG_LEVEL_OFS) begin
         d = r.level;
      end
      return d;
   endfunction

   function automatic ldi_regs_t write_reg(input ldi_regs_t r,
                                           input logic [7:0] a,
                                           input logic [7:0] d);
      ldi_regs_t n;
      n = r;
      if (a == REG_POWER_OFS) begin
         n.power = d;
      end else if (a == REG_LEVEL_OFS) begin
         n.level = d;
      end
      return n;
   endfunction

   // ===========================================================
   // link domain: bit sampler on the serial clock
   // only edges inside a frame exist here; each edge hands one bit
   // over by toggling, the bit stays put until the next edge
   logic rx_bit;
   logic rx_tog;
   logic next_rx_bit;
   logic next_rx_tog;

   always_comb begin
      next_rx_bit = SDA_IN;
      next_rx_tog = ~rx_tog;
   end

   always_ff @(posedge SER_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_bit <= 1'b1;
         rx_tog <= 1'b0;
      end else begin
         rx_bit <= next_rx_bit;
         rx_tog <= next_rx_tog;
      end
   end

   // ===========================================================
   // synchronisers into the system clock
   logic en_s1, en_s2;
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic tog_s1, tog_s2, tog_s3;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         en_s1 <= 1'b0;
         en_s2 <= 1'b0;
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
      end else begin
         en_s1 <= EN;
         en_s2 <= en_s1;
         scl_s1 <= SER_CLK;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= SDA_IN;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         tog_s1 <= rx_tog;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
      end
   end

   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;

   always_comb begin
      start_ev = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
      stop_ev = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
      rise_ev = tog_s2 ^ tog_s3;
      fall_ev = scl_s3 && !scl_s2;
   end

   // ===========================================================
   // transfer engine and register file
   ldi_state_t state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic [7:0] ptr, next_ptr;
   logic [7:0] tx, next_tx;
   logic ack_pend, next_ack_pend;
   logic sda_oe, next_sda_oe;
   ldi_regs_t regs, next_regs;
   logic [7:0] got;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_tx = tx;
      next_ack_pend = ack_pend;
      next_sda_oe = sda_oe;
      next_regs = regs;
      got = {shreg[6:0], rx_bit};
      if (!en_s2) begin
         next_state = ST_IDLE;
         next_bit_cnt = 4'h0;
         next_shreg = 8'h00;
         next_ptr = 8'h00;
         next_tx = 8'h00;
         next_ack_pend = 1'b0;
         next_sda_oe = 1'b0;
         next_regs = REGS_RESET;
      end else if (start_ev) begin
         next_state = ST_ADDR;
         next_bit_cnt = 4'h0;
         next_ack_pend = 1'b0;
         next_sda_oe = 1'b0;
      end else if (stop_ev) begin
         next_state = ST_IDLE;
         next_ack_pend = 1'b0;
         next_sda_oe = 1'b0;
      end else if (rise_ev && state != ST_IDLE) begin
         if (bit_cnt != ACK_BIT_IDX) begin
            next_shreg = got;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == LAST_DATA_BIT) begin
               case (state)
                  ST_ADDR: begin
                     if (got[7:1] == DEV_ADDR_WRITE[7:1]) begin
                        next_ack_pend = 1'b1;
                        if (got[0] == DEV_ADDR_READ[0]) begin
                           next_state = ST_RDATA;
                           next_tx = read_reg(regs, ptr);
                           next_ptr = ptr + 8'h01;
                        end else begin
                           next_state = ST_REG;
                        end
                     end else begin
                        next_state = ST_SKIP;
                     end
                  end
                  ST_REG: begin
                     next_ptr = got;
                     next_state = ST_WDATA;
                     next_ack_pend = 1'b1;
                  end
                  ST_WDATA: begin
                     next_regs = write_reg(regs, ptr, got);
                     next_ptr = ptr + 8'h01;
                     next_ack_pend = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end else begin
            next_bit_cnt = 4'h0;
            next_ack_pend = 1'b0;
            if (state == ST_RDATA && !ack_pend) begin
               if (rx_bit) begin
                  next_state = ST_SKIP;
               end else begin
                  next_tx = read_reg(regs, ptr);
                  next_ptr = ptr + 8'h01;
               end
            end
         end
      end else if (fall_ev) begin
         if (ack_pend && bit_cnt == ACK_BIT_IDX) begin
            next_sda_oe = 1'b1;
         end else if (state == ST_RDATA && bit_cnt != ACK_BIT_IDX) begin
            // open-drain data, driven only for zeros
            next_sda_oe = ~tx[3'h7 - bit_cnt[2:0]];
         end else begin
            next_sda_oe = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         ptr <= 8'h00;
         tx <= 8'h00;
         ack_pend <= 1'b0;
         sda_oe <= 1'b0;
         regs <= REGS_RESET;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         tx <= next_tx;
         ack_pend <= next_ack_pend;
         sda_oe <= next_sda_oe;
         regs <= next_regs;
      end
   end

   // ===========================================================
   // output bridge
   // the divider runs freely; gating only the outputs keeps the
   // polarity timing independent of mode changes
   logic [CW-1:0] div_cnt, next_div_cnt;
   logic phase, next_phase;
   logic hv_pos, next_hv_pos;
   logic hv_neg, next_hv_neg;
   logic normal, next_normal;

   always_comb begin
      next_div_cnt = div_cnt + CW'(1);
      next_phase = phase;
      if (div_cnt == CW'(HALF_CYCLES - 1)) begin
         next_div_cnt = '0;
         next_phase = ~phase;
      end
      next_normal = en_s2 && regs.power[SLEEP_RELEASE_POS];
      // sleep keeps drive off; code zero gives nothing
      next_hv_pos = next_normal && (regs.level != 8'h00) && phase;
      next_hv_neg = next_normal && (regs.level != 8'h00) && !phase;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_cnt <= '0;
         phase <= 1'b0;
         hv_pos <= 1'b0;
         hv_neg <= 1'b0;
         normal <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         phase <= next_phase;
         hv_pos <= next_hv_pos;
         hv_neg <= next_hv_neg;
         normal <= next_normal;
      end
   end

   // ===========================================================
   // outputs
   // serial engine ignores sleep; sleep touches no register
   assign SDA_OUT = 1'b0;
   assign SDA_OE = sda_oe;
   assign HV_OUT_POS = hv_pos;
   assign HV_OUT_NEG = hv_neg;
   assign PEAK_LEVEL_CODE = regs.level;
   assign NORMAL_MODE = normal;

endmodule // ldi_lens_driver

`default_nettype wire

/* File: verification/ldi_lens_driver_properties.sv */
`default_nettype none
module ldi_lens_driver_properties #(
   parameter int HALF_CYCLES = 20
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic SER_CLK,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic EN,
   input wire logic HV_OUT_POS,
   input wire logic HV_OUT_NEG,
   input wire logic [7:0] PEAK_LEVEL_CODE,
   input wire logic NORMAL_MODE
);
   int cnt;
   logic prev;
   logic act;
   assign act = HV_OUT_POS | HV_OUT_NEG;
   // ==========================================
   // phase length; restarts on swap or idle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt <= 0;
         prev <= 1'b0;
      end else begin
         prev <= HV_OUT_POS;
         cnt <= (HV_OUT_POS != prev || !act) ? 1 : cnt + 1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // ==========================================
   // assertions
   AST_HV_SWAP: assert property (
      act |-> HV_OUT_POS != HV_OUT_NEG)
      else $error("bridge outputs not complementary");
   AST_BRIDGE_RATE: assert property (
      act |-> cnt <= HALF_CYCLES)
      else $error("bridge phase too long");
   AST_HV_GATED: assert property (
      (!NORMAL_MODE || PEAK_LEVEL_CODE == 8'h00) [*2]
      |-> !HV_OUT_POS && !HV_OUT_NEG)
      else $error("bridge active while gated");
   AST_EN_SHUT: assert property (
      !EN [*4] |-> PEAK_LEVEL_CODE == 8'h00 && !NORMAL_MODE && !SDA_OE)
      else $error("shutdown not applied");
   AST_NORMAL_EN: assert property (
      NORMAL_MODE |-> $past(EN, 3))
      else $error("normal mode without enable");
   AST_OD_LOW: assert property (
      SDA_OE |-> SDA_OUT == 1'b0)
      else $error("data pin driven high");
   AST_OE_RISE: assert property (
      $rose(SDA_OE) |-> !SER_CLK)
      else $error("data pulled low in clock high");
   AST_OE_FALL: assert property (
      $fell(SDA_OE) && EN |-> !SER_CLK)
      else $error("data released in clock high");
   cover property ($rose(SDA_OE));
   cover property ($rose(NORMAL_MODE));
   cover property ($changed(HV_OUT_POS) && act);
   cover property ($fell(EN));
endmodule // ldi_lens_driver_properties

bind ldi_lens_driver ldi_lens_driver_properties #(
   .HALF_CYCLES(HALF_CYCLES)
) u_prop (
   .CLK(CLK), .RESETN(RESETN), .SER_CLK(SER_CLK), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .EN(EN), .HV_OUT_POS(HV_OUT_POS),
   .HV_OUT_NEG(HV_OUT_NEG), .PEAK_LEVEL_CODE(PEAK_LEVEL_CODE),
   .NORMAL_MODE(NORMAL_MODE));
`default_nettype wire

/* File: verification/ldi_bus_master.sv */
`default_nettype none
module ldi_bus_master (
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   // slow phases: device answers 2-3 system clocks after a fall
   localparam int HP = 60;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // data moves in low phase, held while high
   task automatic bit_x(input logic b, output logic r);
      #(HP / 2);
      sda_drv = b;
      #(HP / 2);
      scl = 1'b1;
      #(HP - 5);
      r = sda;
      #5;
      scl = 1'b0;
   endtask
   task automatic start();
      #(HP / 2);
      sda_drv = 1'b1;
      #(HP / 2);
      scl = 1'b1;
      #(HP);
      sda_drv = 1'b0;
      #(HP);
      scl = 1'b0;
   endtask
   // stop: clock rises first, then data rises while clock stands high
   task automatic stop();
      #(HP / 2);
      sda_drv = 1'b0;
      #(HP / 2);
      scl = 1'b1;
      #(HP);
      sda_drv = 1'b1;
      #(HP);
   endtask
   // eight bits msb first, ninth clock for ack
   task automatic xfer(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
         q[i] = r;
      end
      bit_x(ack_in, ack);
   endtask
endmodule // ldi_bus_master
`default_nettype wire

/* File: verification/tb_top.sv */
`default_nettype none
module tb_top
   import ldi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HC = 20;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic en = 1'b1;
   wire sda;
   logic scl, sda_drv, sda_out, sda_oe, hv_pos, hv_neg, normal, ak;
   logic [7:0] peak, q;
   int n_fail = 0;
   int check_count = 0;
   int c;
   // pull-up: low only when someone pulls
   assign sda = sda_drv & ~(sda_oe & ~sda_out);
   ldi_bus_master mst (.scl(scl), .sda_drv(sda_drv), .sda(sda));
   ldi_lens_driver #(.HALF_CYCLES(HC)) uut (
      .CLK(clk), .RESETN(resetn), .SER_CLK(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .EN(en), .HV_OUT_POS(hv_pos),
      .HV_OUT_NEG(hv_neg), .PEAK_LEVEL_CODE(peak), .NORMAL_MODE(normal));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] b, input logic ea);
      mst.xfer(b, 1'b1, q, ak);
      check(8'(ak), 8'(ea));
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
      mst.start();
      put(DEV_ADDR_WRITE, 1'b0);
      put(p, 1'b0);
      for (int i = 0; i < n; i++) put(d[15 - 8 * i -: 8], 1'b0);
      mst.stop();
      repeat (4) @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] p, input int n, input logic [15:0] e);
      logic [7:0] v;
      wr(p, 16'h0000, 0);
      mst.start();
      put(DEV_ADDR_READ, 1'b0);
      for (int i = 0; i < n; i++) begin
         mst.xfer(8'hff, i == n - 1, v, ak);
         check(v, e[15 - 8 * i -: 8]);
      end
      mst.stop();
      check(8'(sda_oe), 8'h00);
   endtask
   task automatic wchg(output int n);
      logic s;
      s = hv_pos;
      n = 0;
      // sample mid-cycle so the edge that launches the output is settled
      while (hv_pos === s && n < 4 * HC) begin
         @(negedge clk);
         n++;
      end
      if (n >= 4 * HC) begin
         n_fail++;
      end
   endtask
   task automatic t_por();
      check({hv_pos, hv_neg, normal, 5'h00}, 8'h00);
      rd(REG_POWER_OFS, 2, 16'h0000);
      $display("por done");
   endtask
   task automatic t_wr();
      wr(REG_POWER_OFS, 16'h01a5, 2);
      check(peak, 8'ha5);
      check(8'(normal), 8'h01);
      wr(REG_LEVEL_OFS, 16'h0000, 0);
      check(peak, 8'ha5);
      rd(REG_POWER_OFS, 2, 16'h01a5);
      $display("write done");
   endtask
   task automatic t_bridge();
      wchg(c);
      wchg(c);
      check(8'(c), 8'(HC));
      check(8'(hv_pos ^ hv_neg), 8'h01);
      $display("bridge done");
   endtask
   task automatic t_sleep();
      wr(REG_POWER_OFS, 16'h0000, 1);
      check({hv_pos, hv_neg, normal, 5'h00}, 8'h00);
      rd(REG_LEVEL_OFS, 1, 16'ha500);
      check(peak, 8'ha5);
      wr(REG_POWER_OFS, 16'h0100, 1);
      check(8'(normal), 8'h01);
      $display("sleep done");
   endtask
   task automatic t_resv();
      wr(REG_LEVEL_OFS, 16'h0033, 2);
      check({peak[6:0], hv_pos | hv_neg}, 8'h00);
      rd(REG_LEVEL_OFS, 2, 16'h0000);
      mst.start();
      put(8'ha0, 1'b1);
      mst.stop();
      $display("reserved done");
   endtask
   task automatic t_shut();
      wr(REG_LEVEL_OFS, 16'h7e00, 1);
      @(posedge clk);
      en <= 1'b0;
      repeat (6) @(posedge clk);
      check({peak[6:0], normal}, 8'h00);
      mst.start();
      put(DEV_ADDR_WRITE, 1'b1);
      mst.stop();
      @(posedge clk);
      en <= 1'b1;
      repeat (6) @(posedge clk);
      rd(REG_POWER_OFS, 2, 16'h0000);
      $display("shutdown done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_por();
      t_wr();
      t_bridge();
      t_sleep();
      t_resv();
      t_shut();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
